/* rtl/pulse_shaper_consts.vh */
// Constants for the energy pulse output shaper
`ifndef PULSE_SHAPER_CONSTS_VH
`define PULSE_SHAPER_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_WIDTH_LIMIT 14'h210A
`define IDX_SPACING 14'h210B
`define IDX_POLARITY 14'h210C
`define IDX_STATUS 14'h210D

// ==========================================================
// Reset values
`define RST_WIDTH_LIMIT 8'hFF
`define RST_SPACING 8'h00
`define RST_POLARITY 1'b0

// ==========================================================
// Field values and timing
`define WIDTH_NO_LIMIT 8'hFF
`define SPACING_OFF 8'h00
`define SPACING_UNIT_SHIFT 2
`define POL_BIT 0
`define STAT_QUEUE_LSB 0
`define STAT_ACTIVE_LSB 4

// ==========================================================
// Bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

/* rtl/pulse_former.v */
// Shapes one released pulse into a width-limited output level
`timescale 1ns/1ns
`include "pulse_shaper_consts.vh"

module pulse_former #(
  parameter PW = 16
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Release from the spacing logic
  input wire fire_i,
  // Settings
  input wire [7:0] spacing_i,
  input wire [7:0] width_limit_i,
  input wire polarity_i,
  // Output level and activity
  output wire pulse_o,
  output wire active_o
);

  // ==========================================================
  // Width selection
  reg [PW-1:0] period_ff;
  reg [17:0] wcnt_ff;
  reg active_ff;
  reg pulse_ff;
  reg [17:0] nxt_wcnt;
  reg [17:0] len;
  wire bypass = (spacing_i == `SPACING_OFF);
  wire limiting = !bypass && (width_limit_i != `WIDTH_NO_LIMIT);
  wire [17:0] lim_len = {9'h000, width_limit_i, 1'b1} *
                        {10'h000, spacing_i};
  wire [17:0] slot_cyc = {10'h000, spacing_i} << `SPACING_UNIT_SHIFT;
  wire [17:0] cap_len = slot_cyc - 18'h00001;
  wire [17:0] half_gap = slot_cyc >> 1;
  wire [PW:0] per_inc = {1'b0, period_ff} + {{PW{1'b0}}, 1'b1};
  wire [17:0] half_per = {{(18-PW){1'b0}}, per_inc[PW:1]};

  always @* begin
    if (limiting) begin
      // Active phase is (2 x limit + 1) x spacing, kept inside the slot
      len = (lim_len < cap_len) ? lim_len : cap_len;
    end else if (!bypass) begin
      len = half_gap;
    end else begin
      // No queue: half of the last gap between issued pulses
      len = (half_per == 18'h00000) ? 18'h00001 : half_per;
    end
  end

  always @* begin
    if (fire_i) begin
      nxt_wcnt = len;
    end else if (wcnt_ff != 18'h00000) begin
      nxt_wcnt = wcnt_ff - 18'h00001;
    end else begin
      nxt_wcnt = 18'h00000;
    end
  end

  // ==========================================================
  // State
  always @(posedge clock_i) begin
    if (rst_i) begin
      period_ff <= {PW{1'b0}};
      wcnt_ff <= 18'h00000;
      active_ff <= 1'b0;
      pulse_ff <= ~`RST_POLARITY;
    end else begin
      if (fire_i) begin
        period_ff <= {PW{1'b0}};
      end else if (period_ff != {PW{1'b1}}) begin
        period_ff <= per_inc[PW-1:0];
      end
      wcnt_ff <= nxt_wcnt;
      active_ff <= (nxt_wcnt != 18'h00000);
      // Active low while polarity is 0, active high while 1
      pulse_ff <= (nxt_wcnt != 18'h00000) ^ ~polarity_i;
    end
  end

  assign pulse_o = pulse_ff;
  assign active_o = active_ff;

endmodule

/* rtl/energy_pulse_output_shaper.v */
// Energy pulse output shaper: register slave, queues and four lines
//
// Notes on behaviour
// - Queued pulses leave spacing x 4 cycles apart
// - Spacing zero bypasses queue, pulse immediately
// - Active phase capped at (2*limit+1)*spacing cycles
// - Spacing zero or limit 255 gives 50% duty
// - Polarity 0 active low, 1 active high
`timescale 1ns/1ns
`include "pulse_shaper_consts.vh"

module energy_pulse_output_shaper #(
  parameter QW = 8,
  parameter PW = 16
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Pulse issues from the computation engine
  input wire real_energy_req_i,
  input wire reactive_energy_req_i,
  input wire aux_a_req_i,
  input wire aux_b_req_i,
  // Pulse lines
  output wire real_energy_pulse_o,
  output wire reactive_energy_pulse_o,
  output wire aux_pulse_a_o,
  output wire aux_pulse_b_o
);

  // ==========================================================
  // Bus address phase capture
  reg wr_pend_ff;
  reg [13:0] wr_idx_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg hresp_ff;
  wire addr_ok = hsel_i && htrans_i[`HTRANS_NONSEQ_BIT] && hready_i;
  // Only the word index is decoded; size and upper bits are ignored
  wire [13:0] addr_idx = haddr_i[15:2];

  // ==========================================================
  // Registers
  reg [7:0] width_limit_ff;
  reg [7:0] spacing_ff;
  reg polarity_ff;
  reg [7:0] nxt_width_limit;
  reg [7:0] nxt_spacing;
  reg nxt_polarity;
  reg [31:0] rd_mux;
  wire [3:0] queue_busy;
  wire [3:0] line_active;

  // Data phase writes land on this edge
  always @* begin
    nxt_width_limit = width_limit_ff;
    nxt_spacing = spacing_ff;
    nxt_polarity = polarity_ff;
    if (wr_pend_ff) begin
      case (wr_idx_ff)
        `IDX_WIDTH_LIMIT: begin
          nxt_width_limit = hwdata_i[7:0];
        end
        `IDX_SPACING: begin
          nxt_spacing = hwdata_i[7:0];
        end
        `IDX_POLARITY: begin
          nxt_polarity = hwdata_i[`POL_BIT];
        end
        default: begin
          nxt_polarity = polarity_ff;
        end
      endcase
    end
  end

  // Read data follows a write still in its data phase
  always @* begin
    case (addr_idx)
      `IDX_WIDTH_LIMIT: begin
        rd_mux = {24'h000000, nxt_width_limit};
      end
      `IDX_SPACING: begin
        rd_mux = {24'h000000, nxt_spacing};
      end
      `IDX_POLARITY: begin
        rd_mux = {31'h00000000, nxt_polarity};
      end
      // Read only: per-line line active over queue busy
      `IDX_STATUS: begin
        rd_mux = {24'h000000, line_active, queue_busy};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      width_limit_ff <= `RST_WIDTH_LIMIT;
      spacing_ff <= `RST_SPACING;
      polarity_ff <= `RST_POLARITY;
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 14'h0000;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= `HRESP_OKAY;
    end else begin
      width_limit_ff <= nxt_width_limit;
      spacing_ff <= nxt_spacing;
      polarity_ff <= nxt_polarity;
      wr_pend_ff <= addr_ok && hwrite_i;
      if (addr_ok) begin
        wr_idx_ff <= addr_idx;
      end
      if (addr_ok && !hwrite_i) begin
        hrdata_ff <= rd_mux;
      end
      // Never stalls and never errors: zero wait states, always OKAY
      hreadyout_ff <= 1'b1;
      hresp_ff <= `HRESP_OKAY;
    end
  end

  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hreadyout_ff;
  assign hresp_o = hresp_ff;

  // ==========================================================
  // Spacing queues, one per line
  wire bypass = (spacing_ff == `SPACING_OFF);
  wire [9:0] slot_cyc = {2'b00, spacing_ff} << `SPACING_UNIT_SHIFT;
  wire [9:0] slot_len = slot_cyc - 10'h001;
  wire [3:0] req_vec = {aux_b_req_i, aux_a_req_i,
                        reactive_energy_req_i, real_energy_req_i};
  wire [3:0] fire_vec;
  wire [3:0] pulse_vec;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      // Pulses are all alike, so a pending count serves as the queue
      reg [QW-1:0] pend_ff;
      reg [9:0] slot_ff;
      reg [QW-1:0] nxt_pend;
      wire req = req_vec[g];
      wire have = (pend_ff != {QW{1'b0}}) || req;
      // Release at slot expiry, or at once when bypassed
      wire fire = bypass ? req :
                  ((slot_ff == 10'h000) && have);

      always @* begin
        nxt_pend = pend_ff;
        if (bypass) begin
          // Leaving queued mode drops whatever still waits
          nxt_pend = {QW{1'b0}};
        end else if (req && !fire) begin
          // Count saturates so an overflow never wraps to empty
          if (pend_ff != {QW{1'b1}}) begin
            nxt_pend = pend_ff + {{(QW-1){1'b0}}, 1'b1};
          end
        end else if (!req && fire) begin
          nxt_pend = pend_ff - {{(QW-1){1'b0}}, 1'b1};
        end
      end

      always @(posedge clock_i) begin
        if (rst_i) begin
          pend_ff <= {QW{1'b0}};
          slot_ff <= 10'h000;
        end else begin
          pend_ff <= nxt_pend;
          if (bypass) begin
            slot_ff <= 10'h000;
          end else if (fire) begin
            slot_ff <= slot_len;
          end else if (slot_ff != 10'h000) begin
            slot_ff <= slot_ff - 10'h001;
          end
        end
      end

      assign fire_vec[g] = fire;
      assign queue_busy[g] = (pend_ff != {QW{1'b0}});

      pulse_former #(
        .PW(PW)
      ) u_former (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .fire_i(fire_vec[g]),
        .spacing_i(spacing_ff),
        .width_limit_i(width_limit_ff),
        .polarity_i(polarity_ff),
        .pulse_o(pulse_vec[g]),
        .active_o(line_active[g])
      );
    end
  endgenerate

  // ==========================================================
  // Pulse lines
  assign real_energy_pulse_o = pulse_vec[0];
  assign reactive_energy_pulse_o = pulse_vec[1];
  assign aux_pulse_a_o = pulse_vec[2];
  assign aux_pulse_b_o = pulse_vec[3];

endmodule

/* verif/pulse_shaper_props.sv */
// Checker for the energy pulse output shaper
`timescale 1ns/1ns
module pulse_shaper_props (
  // Clock, reset and bus
  input wire clock_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  // Engine issue and lines
  input wire real_energy_req_i,
  input wire real_energy_pulse_o,
  input wire reactive_energy_pulse_o,
  input wire aux_pulse_a_o,
  input wire aux_pulse_b_o
);
  // ====
  // Shadow of the settings and line timing
  logic wr, pol, act, pol_ok;
  logic [1:0] pd;
  logic [13:0] ix;
  logic [7:0] sp, lim;
  logic [15:0] w, since;
  assign act = real_energy_pulse_o == pol;
  assign pol_ok = pd == {2{pol}};
  always @(posedge clock_i) begin
    wr <= !rst_i & hsel_i & htrans_i[1] & hwrite_i & hready_i;
    ix <= haddr_i[15:2];
    pd <= {pd[0], pol};
    w <= act ? w + 16'h1 : 16'h0;
    if (sp == 8'h00)
      since <= 16'hFFFF;
    else if ($rose(act))
      since <= 16'h1;
    else if (since != 16'hFFFF)
      since <= since + 16'h1;
    if (rst_i) begin
      sp <= 8'h00;
      lim <= 8'hFF;
      pol <= 1'b0;
    end else if (wr) begin
      if (ix == 14'h210A)
        lim <= hwdata_i[7:0];
      if (ix == 14'h210B)
        sp <= hwdata_i[7:0];
      if (ix == 14'h210C)
        pol <= hwdata_i[0];
    end
  end
  // ====
  // Properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_reset_idle: assert property ($fell(rst_i) |->
    {real_energy_pulse_o, reactive_energy_pulse_o, aux_pulse_a_o,
    aux_pulse_b_o} == 4'hF) else $error("lines active after reset");
  a_bypass_now: assert property (sp == 8'h00 &&
    real_energy_req_i && pol_ok |=> act) else $error("bypass pulse late");
  a_spacing_gap: assert property ($rose(act) && sp != 8'h00 &&
    pol_ok |-> since >= 4 * sp) else $error("pulses too close");
  a_width_cap: assert property ($fell(act) && sp != 8'h00 &&
    lim != 8'hFF && pol_ok |-> w <= (2 * lim + 1) * sp && w < 4 * sp)
    else $error("pulse too wide");
  a_half_duty: assert property ($fell(act) && sp != 8'h00 &&
    lim == 8'hFF && pol_ok |-> w == 2 * sp) else $error("duty not half");
  a_release_due: assert property (sp != 8'h00 && sp < 8'hFA &&
    real_energy_req_i && pol_ok |-> ##[1:1000] $rose(act))
    else $error("queued pulse not released");
endmodule
bind energy_pulse_output_shaper pulse_shaper_props chk (
  .clock_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
  .hwdata_i,
  .real_energy_req_i, .real_energy_pulse_o, .reactive_energy_pulse_o,
  .aux_pulse_a_o, .aux_pulse_b_o);

/* verif/pulse_counter.sv */
// Far-side pulse counter watching one pulse line
`timescale 1ns/1ns
module pulse_counter (
  // Clock and sensed line
  input wire clock_i,
  input wire pol_i,
  input wire line_i,
  // Count of pulses, last spacing and last width
  output logic [15:0] n_o = 16'h0,
  output logic [15:0] gap_o = 16'h0,
  output logic [15:0] wid_o = 16'h0
);
  logic a;
  logic a_d = 1'b0;
  logic [15:0] t = 16'h0;
  logic [15:0] w = 16'h0;
  assign a = line_i == pol_i;
  always @(posedge clock_i) begin
    a_d <= a;
    t <= t + 16'h1;
    w <= a ? w + 16'h1 : 16'h0;
    if (a && !a_d) begin
      n_o <= n_o + 16'h1;
      gap_o <= t;
      t <= 16'h1;
    end
    if (!a && a_d)
      wid_o <= w;
  end
endmodule

/* verif/energy_pulse_output_shaper_tb.sv */
// Self-checking bench for the energy pulse output shaper
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); \
  end \
end
module energy_pulse_output_shaper_tb;
  // ====
  // Stimulus and observed signals
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, r, sp, ew;
  logic hreadyout_o, hresp_o;
  logic pol = 1'b0;
  logic [3:0] req = 4'h0;
  logic [3:0] line;
  logic [15:0] n, gap, wid, n0;
  int err_count = 0;
  int samples_checked = 0;
  typedef struct {logic [31:0] a; logic w; logic [31:0] d, e;} row_t;
  row_t rows[9] = '{'{32'h8428, 1'b0, 32'h0, 32'hFF},
    '{32'h842C, 1'b0, 32'h0, 32'h0}, '{32'h8430, 1'b0, 32'h0, 32'h0},
    '{32'h9000, 1'b0, 32'h0, 32'h0}, '{32'h8428, 1'b1, 32'hFFFFFF05, 32'h5},
    '{32'h842C, 1'b1, 32'h3, 32'h3}, '{32'h8430, 1'b1, 32'h3, 32'h1},
    '{32'h9000, 1'b1, 32'h5, 32'h0}, '{32'h8434, 1'b1, 32'hFF, 32'h0}};
  logic [7:0] lims[3] = '{8'hFF, 8'h00, 8'h01};
  always #2 clock_i = ~clock_i;
  energy_pulse_output_shaper dut (
    .clock_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .real_energy_req_i(req[0]),
    .reactive_energy_req_i(req[1]), .aux_a_req_i(req[2]),
    .aux_b_req_i(req[3]), .real_energy_pulse_o(line[0]),
    .reactive_energy_pulse_o(line[1]), .aux_pulse_a_o(line[2]),
    .aux_pulse_b_o(line[3]));
  pulse_counter far (.clock_i, .pol_i(pol), .line_i(line[0]), .n_o(n),
    .gap_o(gap), .wid_o(wid));
  // ====
  // Bus cycle and verdict
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= a;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  task give_verdict;
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clock_i);
    err_count++;
    give_verdict;
  end
  // ====
  // Test sequence
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    foreach (rows[i]) begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      `CHK("reg", rows[i].e, r)
      `CHK("resp", 1'b0, hresp_o)
    end
    bus(1'b1, 32'h8428, 32'hFF);
    bus(1'b1, 32'h842C, 32'h0);
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      bus(1'b1, 32'h8430, {31'h0, p[0]});
      repeat (4) @(posedge clock_i);
      req <= 4'hF;
      repeat (2) @(posedge clock_i);
      req <= 4'h0;
      #1;
      `CHK("bypass", {4{p[0]}}, line)
      repeat (4) @(posedge clock_i);
      #1;
      `CHK("idle", {4{~p[0]}}, line)
      @(posedge clock_i);
    end
    n0 = n;
    for (int k = 0; k < 3; k++) begin
      req <= 4'h1;
      @(posedge clock_i);
      req <= 4'h0;
      repeat (19) @(posedge clock_i);
    end
    `CHK("bypass count", 16'h3, n - n0)
    `CHK("bypass gap", 16'h14, gap)
    `CHK("bypass width", 16'hA, wid)
    sp = 1950 / 6 / 4;
    bus(1'b1, 32'h842C, sp);
    foreach (lims[i]) begin
      bus(1'b1, 32'h8428, {24'h0, lims[i]});
      n0 = n;
      req <= 4'hF;
      repeat (3) @(posedge clock_i);
      req <= 4'h0;
      bus(1'b0, 32'h8434, 32'h0);
      `CHK("status", 32'hFF, r)
      repeat (1100) @(posedge clock_i);
      `CHK("count", 16'h3, n - n0)
      `CHK("gap", 4 * sp, gap)
      ew = (lims[i] == 8'hFF) ? 2 * sp : (2 * lims[i] + 1) * sp;
      `CHK("width", ew, wid)
      `CHK("lines idle", 4'h0, line)
    end
    rst_i <= 1'b1;
    pol <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    `CHK("reset lines", 4'hF, line)
    @(posedge clock_i);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, rows[i].a, 32'h0);
      `CHK("reset reg", rows[i].e, r)
    end
    give_verdict;
  end
endmodule
